// ---- verilog/seg_disp_ctrl.sv ----
// multiplexed segment display controller with an AHB-Lite register slave
// assumes arst_n is asynchronous, pins other than the bus come from outside the clock domain
//
// What this block does
// - drives segments and multiplexes all digits itself, no outside scanning needed
// - host writes any digit register at random, address decoded inside
// - internal timebase steps through stored digit values in sequence
// - digit port as input lets outside pick any digit directly
// - several controllers combine for wider segments and more digits
// - segment outputs drive directly and can go high impedance
// - rom mode decodes 4-bit code into segment pattern
// - direct mode passes 8 stored bits straight to segments
// - dead interval with no digit active between successive digit strobes
// - store only during an enabled write; nothing latched by select alone
// - digit lines as outputs are strobed in turn with matching data
// - digit lines as inputs stop scan and show selected digit
// - segments high impedance whenever segment enable is deasserted
`timescale 1ns/100ps
module seg_disp_ctrl
  import seg_disp_pkg::*;
#(
  parameter int DIGITS   = seg_disp_pkg::NUM_DIGITS,
  parameter int ON_CYC   = seg_disp_pkg::DIGIT_ON_CYC,
  parameter int DEAD_CYC = seg_disp_pkg::BLANK_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              seg_oe_n,
  input  wire logic [DIGITS-1:0] digit_in,
  output logic      [DIGITS-1:0] digit_out,
  output logic      [DIGITS-1:0] digit_oe,
  output logic      [seg_disp_pkg::SEG_W-1:0] seg_out,
  output logic                   seg_oe
);
  import seg_disp_pkg::*;

  localparam int IDX_W = (DIGITS > 1) ? $clog2(DIGITS) : 1;

  typedef struct packed {
    logic [1:0]                   rst_sync;
    logic [1:0]                   oe_sync0;
    logic [DIGITS-1:0]            din_s0;
    logic [DIGITS-1:0]            din_s1;
    logic                         seg_en;
    logic                         wr_pend;
    logic [31:0]                  wr_addr;
    logic [31:0]                  rdata;
    logic [1:0]                   ctrl;
    logic [DIGITS-1:0][SEG_W-1:0] digit_store;
    scan_state_t                  state;
    logic [IDX_W-1:0]             idx;
    logic [CNT_W-1:0]             cnt;
    logic [DIGITS-1:0]            dig;
    logic [SEG_W-1:0]             seg;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic   rst_n;

  // rom: 4-bit code to 7 segment pattern, bit0 = segment a
  function automatic logic [6:0] rom7(input logic [CODE_W-1:0] code);
    case (code)
      4'h0: rom7 = 7'h3F;
      4'h1: rom7 = 7'h06;
      4'h2: rom7 = 7'h5B;
      4'h3: rom7 = 7'h4F;
      4'h4: rom7 = 7'h66;
      4'h5: rom7 = 7'h6D;
      4'h6: rom7 = 7'h7D;
      4'h7: rom7 = 7'h07;
      4'h8: rom7 = 7'h7F;
      4'h9: rom7 = 7'h6F;
      4'hA: rom7 = 7'h77;
      4'hB: rom7 = 7'h7C;
      4'hC: rom7 = 7'h39;
      4'hD: rom7 = 7'h5E;
      4'hE: rom7 = 7'h79;
      default: rom7 = 7'h71;
    endcase
  endfunction

  // pattern for one stored value; decimal point bypasses the rom
  function automatic logic [SEG_W-1:0] pattern(input logic [SEG_W-1:0] v, input logic direct);
    if (direct) begin
      pattern = v;
    end else begin
      pattern = {v[DP_BIT], rom7(v[CODE_W-1:0])};
    end
  endfunction

  // index of the single high digit input, lowest wins if outside breaks its promise
  function automatic logic [IDX_W-1:0] onehot_idx(input logic [DIGITS-1:0] d);
    onehot_idx = '0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      if (d[i]) begin
        onehot_idx = IDX_W'(i);
      end
    end
  endfunction

  assign rst_n = st_reg.rst_sync[1];

  always_comb begin
    logic [31:0] widx;
    logic        dio_in;
    logic        direct;
    st_next = st_reg;
    widx    = 32'h0000_0000;
    dio_in  = st_reg.ctrl[CTRL_DIO_BIT];
    direct  = st_reg.ctrl[CTRL_DIRECT_BIT];
    st_next.rst_sync = {st_reg.rst_sync[0], 1'b1};
    // pins pass two flops before use
    st_next.din_s0   = digit_in;
    st_next.din_s1   = st_reg.din_s0;
    st_next.oe_sync0 = {st_reg.oe_sync0[0], seg_oe_n};
    // enable flag resets to off, so a high pin never lets the segments glitch on
    st_next.seg_en   = !st_reg.oe_sync0[1];
    // bus write lands in the data phase
    st_next.wr_pend = 1'b0;
    if (st_reg.wr_pend) begin
      if (st_reg.wr_addr == ADDR_CTRL) begin
        st_next.ctrl = hwdata[1:0];
      end else if (st_reg.wr_addr >= ADDR_DIGIT0 && st_reg.wr_addr < ADDR_DIGIT0 + 32'(4 * DIGITS)) begin
        widx = (st_reg.wr_addr - ADDR_DIGIT0) >> 2;
        st_next.digit_store[widx[IDX_W-1:0]] = hwdata[SEG_W-1:0];
      end
    end
    if (hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)) begin
      st_next.wr_pend = hwrite;
      st_next.wr_addr = haddr;
      st_next.rdata   = 32'h0000_0000;
      if (!hwrite) begin
        if (haddr == ADDR_CTRL) begin
          st_next.rdata = {30'h0000_0000, st_reg.ctrl};
        end else if (haddr == ADDR_STATUS) begin
          // fields placed one by one so the word stays 32 bits for up to 16 digits
          st_next.rdata[STAT_IDX_LSB +: 4]      = 4'(st_reg.idx);
          st_next.rdata[STAT_STATE_LSB +: 2]    = st_reg.state;
          st_next.rdata[STAT_DIG_LSB +: DIGITS] = st_reg.dig;
        end else if (haddr >= ADDR_DIGIT0 && haddr < ADDR_DIGIT0 + 32'(4 * DIGITS)) begin
          widx = (haddr - ADDR_DIGIT0) >> 2;
          st_next.rdata = {24'h00_0000, st_reg.digit_store[widx[IDX_W-1:0]]};
        end
      end
    end
    // digit scan: show then dead time, on-time and dead time counted in cycles
    case (st_reg.state)
      ST_BLANK: begin
        st_next.dig = '0;
        st_next.seg = '0;
        if (dio_in) begin
          st_next.state = ST_HELD;
        end else if (st_reg.cnt >= CNT_W'(DEAD_CYC - 1)) begin
          st_next.cnt   = '0;
          st_next.state = ST_SHOW;
          st_next.idx   = (st_reg.idx == IDX_W'(DIGITS - 1)) ? '0 : st_reg.idx + 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      ST_SHOW: begin
        st_next.dig      = '0;
        st_next.dig[st_reg.idx] = 1'b1;
        st_next.seg      = pattern(st_reg.digit_store[st_reg.idx], direct);
        if (dio_in) begin
          // lines turn around now, so drop the strobe at once
          st_next.state = ST_HELD;
          st_next.dig   = '0;
          st_next.seg   = '0;
        end else if (st_reg.cnt >= CNT_W'(ON_CYC - 1)) begin
          st_next.cnt   = '0;
          st_next.state = ST_BLANK;
          st_next.dig   = '0;
          st_next.seg   = '0;
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      ST_HELD: begin
        // scan stopped; outside selects one digit by its lines
        st_next.dig = '0;
        st_next.cnt = '0;
        st_next.idx = onehot_idx(st_reg.din_s1);
        st_next.seg = (st_reg.din_s1 != '0) ? pattern(st_reg.digit_store[onehot_idx(st_reg.din_s1)], direct) : '0;
        if (!dio_in) begin
          // leave blanked so the scan restarts from a dark gap
          st_next.state = ST_BLANK;
          st_next.seg   = '0;
        end
      end
      default: begin
        st_next.state = ST_BLANK;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else if (!rst_n) begin
      st_reg          <= '0;
      st_reg.rst_sync <= st_next.rst_sync;
      st_reg.oe_sync0 <= st_next.oe_sync0; // keep the pin synchroniser filling during reset
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs; several devices share segment and digit lines through their enables
  assign hrdata    = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign digit_out = st_reg.dig;
  assign digit_oe  = st_reg.ctrl[CTRL_DIO_BIT] ? '0 : {DIGITS{1'b1}};
  assign seg_out   = st_reg.seg;
  assign seg_oe    = rst_n && st_reg.seg_en;
endmodule

// ---- verilog/seg_disp_pkg.sv ----
// constants shared by the multiplexed segment display controller
// assumes a single 25 MHz core clock
package seg_disp_pkg;
  localparam int CLK_MHZ         = 25;
  localparam int DIGIT_ON_US     = 400;  // least digit on time; the controller strobes each digit for DIGIT_ON_CYC - 1 cycles
  localparam int BLANK_US        = 50;   // least interdigit blanking
  localparam int DIGIT_ON_CYC    = DIGIT_ON_US * CLK_MHZ;
  localparam int BLANK_CYC       = BLANK_US * CLK_MHZ;
  localparam int NUM_DIGITS      = 6;
  localparam int CODE_W          = 4;
  localparam int SEG_W           = 8;
  localparam int DP_BIT          = 7;
  localparam int CNT_W           = 16;
  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_DIGIT0 = 32'h0000_0010;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0]  HTRANS_SEQ    = 2'b11;
  localparam logic [1:0]  CTRL_RESET    = 2'b00; // bit0 direct-data mode, bit1 digit port input
  localparam int CTRL_DIRECT_BIT = 0;
  localparam int CTRL_DIO_BIT    = 1;
  // status word field positions
  localparam int STAT_IDX_LSB    = 0;
  localparam int STAT_STATE_LSB  = 8;
  localparam int STAT_DIG_LSB    = 16;
  typedef enum logic [1:0] {ST_BLANK = 2'b00, ST_SHOW = 2'b01, ST_HELD = 2'b11} scan_state_t;
endpackage

// ---- tb/seg_disp_ctrl_properties.sv ----
// pin checker for the segment display controller
// assumes bind onto seg_disp_ctrl, one clock domain
`timescale 1ns/100ps
module seg_disp_chk #(parameter int DIGITS = 6) (
  input wire logic              core_clk,
  input wire logic              arst_n,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              seg_oe_n,
  input wire logic [DIGITS-1:0] digit_out,
  input wire logic [DIGITS-1:0] digit_oe,
  input wire logic [7:0]        seg_out,
  input wire logic              seg_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus stall");
  property p_one; $onehot0(digit_out); endproperty
  a_one: assert property (p_one) else $error("two strobes");
  // one cycle of slack while the direction bit settles
  property p_in; (digit_oe == '0)[*2] |-> digit_out == '0; endproperty
  a_in: assert property (p_in) else $error("strobe in input mode");
  property p_gap; $fell(|digit_out) |-> (digit_out == '0)[*4]; endproperty
  a_gap: assert property (p_gap) else $error("dead gap short");
  property p_hold; $rose(|digit_out) |=> ($stable(digit_out) || digit_oe == '0)[*8]; endproperty
  a_hold: assert property (p_hold) else $error("strobe short");
  property p_blank; (digit_oe != '0 && digit_out == '0)[*2] |-> seg_out == '0; endproperty
  a_blank: assert property (p_blank) else $error("segments lit in gap");
  // enable pin is synchronised, so allow its lag
  property p_hiz; seg_oe_n[*8] |-> !seg_oe; endproperty
  a_hiz: assert property (p_hiz) else $error("segments driven");
  property p_on; !seg_oe_n[*8] |-> seg_oe; endproperty
  a_on: assert property (p_on) else $error("segments floating");
endmodule
bind seg_disp_ctrl seg_disp_chk #(.DIGITS(DIGITS)) u_chk (.core_clk, .arst_n, .hreadyout, .hresp,
  .seg_oe_n, .digit_out, .digit_oe, .seg_out, .seg_oe);

// ---- tb/digit_driver.sv ----
// outside party on the digit lines, picks one digit in input mode
// assumes digit_oe is high while the controller drives a line
`timescale 1ns/100ps
module digit_driver #(parameter int DIGITS = 6) (
  input  wire logic [DIGITS-1:0] digit_out,
  input  wire logic [DIGITS-1:0] digit_oe,
  input  wire logic [DIGITS-1:0] pick,
  output logic      [DIGITS-1:0] line
);
  // wire level: controller where it drives, else the pick (one hot at most)
  assign line = (digit_out & digit_oe) | (pick & ~digit_oe);
endmodule

// ---- tb/mux_segment_display_controller_tb.sv ----
// testbench for the segment display controller
// assumes bench acts as sole AHB-Lite master, short scan counts
`timescale 1ns/100ps
module mux_segment_display_controller_tb;
  import seg_disp_pkg::*;
  logic        core_clk, arst_n, hwrite, seg_oe_n, hreadyout, hresp, seg_oe;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [5:0]  pick, line, digit_out, digit_oe;
  logic [7:0]  seg_out;
  int          errors = 0, n_tests = 0;
  seg_disp_ctrl #(.ON_CYC(20), .DEAD_CYC(5)) u_dut (.core_clk, .arst_n, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .seg_oe_n,
    .digit_in(line), .digit_out, .digit_oe, .seg_out, .seg_oe);
  digit_driver u_drv (.digit_out, .digit_oe, .pick, .line);
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // single word transfer; waits on ready, no assumed latency
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  function automatic logic [31:0] val(int i);
    return 32'(17 * i + 3);
  endfunction
  // next new strobe, bounded
  task automatic strobe(output logic [5:0] s);
    int n;
    n = 0;
    while (digit_out !== '0 && n < 99) begin
      @(posedge core_clk);
      n++;
    end
    while (digit_out === '0 && n < 99) begin
      @(posedge core_clk);
      n++;
    end
    s = digit_out;
  endtask
  task automatic t_scan;
    logic [31:0] q;
    logic [5:0]  s, e;
    int          k;
    xfer(1, ADDR_CTRL, 1, q);
    for (int i = 0; i < 6; i++) xfer(1, ADDR_DIGIT0 + 4 * i, val(i), q);
    chk("oe out", 32'h0000_003f, digit_oe);
    strobe(s);
    for (int j = 0; j < 8; j++) begin
      k = 0;
      for (int i = 0; i < 6; i++) if (s[i]) k = i;
      chk("seg", val(k), seg_out);
      e = {s[4:0], s[5]};
      strobe(s);
      chk("strobe", e, s);
    end
  endtask
  task automatic t_reg;
    logic [31:0] q;
    xfer(1, 32'h0000_0100, 32'hffff_ffff, q);
    xfer(0, 32'h0000_0100, 0, q);
    chk("unmapped", 0, q);
    xfer(0, ADDR_CTRL, 0, q);
    chk("ctrl", 1, q);
  endtask
  task automatic t_input;
    logic [31:0] q;
    xfer(1, ADDR_CTRL, 3, q);
    pick <= 6'h08;
    repeat (8) @(posedge core_clk);
    chk("seg in", val(3), seg_out);
    chk("strobe in", 0, digit_out);
    chk("oe in", 0, digit_oe);
    xfer(0, ADDR_STATUS, 0, q);
    chk("status", {22'h00_0000, ST_HELD, 8'h03}, q);
    pick <= 6'h00;
    repeat (8) @(posedge core_clk);
    chk("seg none", 0, seg_out);
    xfer(1, ADDR_CTRL, 1, q);
  endtask
  // rom mode: code 8 lights every segment, decimal point passes straight through
  task automatic t_rom;
    logic [31:0] q;
    xfer(1, ADDR_DIGIT0, 32'h0000_0088, q);
    xfer(1, ADDR_DIGIT0 + 4, 32'h0000_0001, q);
    xfer(1, ADDR_CTRL, 2, q);
    pick <= 6'h01;
    repeat (8) @(posedge core_clk);
    chk("rom 8 dp", 32'h0000_00ff, seg_out);
    pick <= 6'h02;
    repeat (8) @(posedge core_clk);
    chk("rom 1", 32'h0000_0006, seg_out);
    pick <= 6'h00;
    repeat (8) @(posedge core_clk);
    xfer(1, ADDR_CTRL, 1, q);
  endtask
  task automatic t_oe;
    seg_oe_n <= 1;
    repeat (8) @(posedge core_clk);
    chk("seg_oe off", 0, seg_oe);
    seg_oe_n <= 0;
    repeat (8) @(posedge core_clk);
    chk("seg_oe on", 1, seg_oe);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {arst_n, hwrite, htrans, haddr, hwdata, seg_oe_n, pick} = '0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1;
    repeat (3) @(posedge core_clk);
    t_scan;
    t_reg;
    t_input;
    t_rom;
    t_oe;
    end_sim;
  end
  // hang guard, several times the expected run
  initial begin
    repeat (4000) @(posedge core_clk);
    errors++;
    end_sim;
  end
endmodule
